/* lcf_carry_cell.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// One arithmetic logic cell of the carry path.
// ****************************************************************
module lcf_carry_cell (
   input  wire logic i_clk,       // Fabric clock.
   input  wire logic i_rst,       // Synchronous reset.
   input  wire logic i_clr,       // Register clear.
   input  wire logic i_a,         // Operand bit.
   input  wire logic i_b,         // Second operand bit.
   input  wire logic i_cin,       // Carry from the lower bit.
   input  wire logic i_acc,       // Accumulate: register feeds back as operand.
   input  wire logic i_sel0,      // Output 0 takes register when high.
   input  wire logic i_sel1,      // Output 1 takes register when high.
   output logic      o_out0,      // First cell output.
   output logic      o_out1,      // Second cell output.
   output logic      o_cout,      // Carry to the higher bit.
   output logic      o_reg        // Register contents.
);
   // Cell state is its single register.
   typedef struct packed {
      logic r;
   } lcf_cell_type;

   lcf_cell_type st_q;    // Registered state.
   lcf_cell_type st_d;    // Next state.
   logic         op_a;    // First operand after accumulator choice.
   logic         sum;     // Table result.

   // The table computes sum; the majority carry goes up the path.
   always_comb begin
      op_a   = i_acc ? st_q.r : i_a;
      sum    = op_a ^ i_b ^ i_cin;
      o_cout = lcf_pkg::maj3(op_a, i_b, i_cin);
      st_d.r = (i_rst | i_clr) ? 1'b0 : sum;
      // Each output independently picks table or register.
      o_out0 = i_sel0 ? st_q.r : sum;
      o_out1 = i_sel1 ? st_q.r : sum;
      o_reg  = st_q.r;
   end

   // Register the cell state.
   always_ff @(posedge i_clk) begin
      st_q <= st_d;
   end
endmodule
`default_nettype wire

/* lcf_clear_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Macrocell clear generator and selector.
// ****************************************************************
module lcf_clear_ctl (
   input  wire logic       i_clk,    // Fabric clock.
   input  wire logic       i_rst,    // Synchronous reset.
   input  wire logic [3:0] i_glb,    // Global signals.
   input  wire logic [1:0] i_local,  // Local routing clears.
   input  wire logic [7:0] i_cfg,    // Clear configuration.
   output logic            o_clr     // Selected macrocell clear, registered.
);
   typedef struct packed {
      logic clr;
   } lcf_clrst_type;

   lcf_clrst_type st_q;  // Registered clear.
   lcf_clrst_type st_d;  // Next clear.
   logic          c0;    // First derived clear.
   logic          c1;    // Second derived clear.
   lcf_pkg::lcf_clr_sel_type sel; // Macrocell choice.

   // Derive two clears, invert optionally, then select one or none.
   always_comb begin
      c0 = i_cfg[lcf_pkg::FLD_CLR0_LOCAL] ? i_local[0] : i_glb[0];
      c1 = i_cfg[lcf_pkg::FLD_CLR1_LOCAL] ? i_local[1] : i_glb[1];
      c0 = c0 ^ i_cfg[lcf_pkg::FLD_CLR0_INV];
      c1 = c1 ^ i_cfg[lcf_pkg::FLD_CLR1_INV];
      sel = lcf_pkg::lcf_clr_sel_type'(i_cfg[lcf_pkg::FLD_CLR_SEL +: 2]);
      unique case (sel)
         lcf_pkg::CLR_ZERO: st_d.clr = c0;
         lcf_pkg::CLR_ONE:  st_d.clr = c1;
         default:           st_d.clr = 1'b0;
      endcase
      if (i_rst) begin
         st_d.clr = 1'b0;
      end
      o_clr = st_q.clr;
   end

   always_ff @(posedge i_clk) begin
      st_q <= st_d;
   end
endmodule
`default_nettype wire

/* lcf_fabric.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Logic cell fabric slice: carry adder, cascade, clears, globals.
// ****************************************************************
module lcf_fabric #(
   parameter int GROUPS = lcf_pkg::GROUPS
) (
   input  wire logic        I_CLOCK,    // Fabric clock, 40 MHz.
   input  wire logic        I_RST,      // Synchronous reset, active high.
   input  wire logic [3:0]  I_ADDR,     // Register address.
   input  wire logic [31:0] I_WDATA,    // Write data.
   input  wire logic        I_WR,       // Write strobe.
   input  wire logic        I_RD,       // Read strobe.
   input  wire logic [3:0]  I_GPIN,     // Dedicated global input pins.
   input  wire logic [1:0]  I_LCLR,     // Local routing clear sources.
   output logic [31:0]      O_RDATA,    // Read data, cycle after strobe.
   output logic [3:0]       O_GLOBAL,   // Global control signals.
   output logic             O_CARRY,    // Final carry on general routing.
   output logic             O_CASCADE,  // Cascade result.
   output logic             O_CLR       // Selected macrocell clear.
);
   localparam int N = lcf_pkg::CELLS_PER_GROUP * GROUPS / 2;  // Cells on one path.

   // ****************************************************************
   // State.
   // ****************************************************************
   typedef struct packed {
      logic [7:0]  cell_cfg;
      logic [7:0]  clr_cfg;
      logic [7:0]  glb_cfg;
      logic [31:0] opa;
      logic [31:0] opb;
      logic [31:0] cas_in;
      logic [31:0] rdata;
      logic [3:0]  glb;
      logic [1:0]  div;
      logic        carry;
      logic        cascade;
   } lcf_top_type;

   lcf_top_type st_q;           // Registered state.
   lcf_top_type st_d;           // Next state.
   logic [N:0]  chain;          // Carry path, one stage per cell.
   logic [N-1:0] out0;          // First outputs of the cells.
   logic [N-1:0] out1;          // Second outputs of the cells.
   logic [N-1:0] regs;          // Cell registers.
   logic         clr;           // Selected clear.
   logic         cas;           // Cascade value.
   logic [31:0]  cas_eff;       // Cascade inputs after inversion.

   // Path order: cells of group 0 then group 2, so alternate groups link.
   assign chain[0] = st_q.cell_cfg[lcf_pkg::FLD_CARRY_IN];

   // ****************************************************************
   // Carry path cells.
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_cell
         // Carry goes straight to the next cell; groups hop even to even.
         lcf_carry_cell u_cell (
            .i_clk  (I_CLOCK),
            .i_rst  (I_RST),
            .i_clr  (clr),
            .i_a    (st_q.opa[g % 32]),
            .i_b    (st_q.opb[g % 32]),
            .i_cin  (chain[g]),
            .i_acc  (st_q.cell_cfg[lcf_pkg::FLD_ACC_EN]),
            .i_sel0 (st_q.cell_cfg[lcf_pkg::FLD_OUT0_SEL]),
            .i_sel1 (st_q.cell_cfg[lcf_pkg::FLD_OUT1_SEL]),
            .o_out0 (out0[g]),
            .o_out1 (out1[g]),
            .o_cout (chain[g+1]),
            .o_reg  (regs[g])
         );
      end
   endgenerate

   // ****************************************************************
   // Clear control.
   // ****************************************************************
   lcf_clear_ctl u_clr (
      .i_clk   (I_CLOCK),
      .i_rst   (I_RST),
      .i_glb   (st_q.glb),
      .i_local (I_LCLR),
      .i_cfg   (st_q.clr_cfg),
      .o_clr   (clr)
   );

   // ****************************************************************
   // Next state.
   // ****************************************************************
   always_comb begin
      st_d = st_q;
      // Cascade: AND of all 32 cascade inputs; OR by inverting both ends.
      cas_eff = st_q.cell_cfg[lcf_pkg::FLD_CAS_OR] ? ~st_q.cas_in : st_q.cas_in;
      cas = &cas_eff;
      cas = cas ^ st_q.cell_cfg[lcf_pkg::FLD_CAS_OR];
      // Final carry lands in an extra cell driving routing.
      st_d.carry = chain[N];
      st_d.cascade = cas;
      // Globals from pins or from internal divider and configuration bits.
      st_d.div = st_q.div + 2'h1;
      for (int i = 0; i < lcf_pkg::NUM_GLOBALS; i++) begin
         st_d.glb[i] = st_q.glb_cfg[i] ? (i[0] ? st_q.glb_cfg[4+i] : st_q.div[1]) : I_GPIN[i];
      end
      if (I_WR) begin
         unique case (I_ADDR)
            lcf_pkg::ADDR_CELL_CFG:  st_d.cell_cfg = I_WDATA[7:0];
            lcf_pkg::ADDR_CHAIN_CFG: st_d.cas_in   = I_WDATA;
            lcf_pkg::ADDR_CLR_CFG:   st_d.clr_cfg  = I_WDATA[7:0];
            lcf_pkg::ADDR_GLB_CFG:   st_d.glb_cfg  = I_WDATA[7:0];
            lcf_pkg::ADDR_OPA:       st_d.opa      = I_WDATA;
            lcf_pkg::ADDR_OPB:       st_d.opb      = I_WDATA;
            default:                 st_d.opa      = st_q.opa;
         endcase
      end
      st_d.rdata = lcf_pkg::RST_ZERO;
      if (I_RD) begin
         unique case (I_ADDR)
            lcf_pkg::ADDR_CELL_CFG:  st_d.rdata = {24'h00_0000, st_q.cell_cfg};
            lcf_pkg::ADDR_CHAIN_CFG: st_d.rdata = st_q.cas_in;
            lcf_pkg::ADDR_CLR_CFG:   st_d.rdata = {24'h00_0000, st_q.clr_cfg};
            lcf_pkg::ADDR_GLB_CFG:   st_d.rdata = {24'h00_0000, st_q.glb_cfg};
            // Sum status: both outputs of the low cells and the carry.
            lcf_pkg::ADDR_SUM_STAT:  st_d.rdata = {out1[14:0], chain[N], out0[15:0]};
            lcf_pkg::ADDR_CAS_STAT:  st_d.rdata = {28'h000_0000, clr, st_q.glb[0], regs[0], st_q.cascade};
            lcf_pkg::ADDR_OPA:       st_d.rdata = st_q.opa;
            lcf_pkg::ADDR_OPB:       st_d.rdata = st_q.opb;
            default:                 st_d.rdata = lcf_pkg::RST_ZERO;
         endcase
      end
      if (I_RST) begin
         st_d = '0;
      end
   end

   // Register all top state.
   always_ff @(posedge I_CLOCK) begin
      st_q <= st_d;
   end

   // Outputs come straight from flip-flops.
   assign O_RDATA   = st_q.rdata;
   assign O_GLOBAL  = st_q.glb;
   assign O_CARRY   = st_q.carry;
   assign O_CASCADE = st_q.cascade;
   assign O_CLR     = clr;
endmodule
`default_nettype wire

/* lcf_fabric_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checks of the logic cell fabric slice.
// ****************************************************************
module lcf_fabric_checker #(
   parameter int GROUPS = 4
) (
   input  wire logic        I_CLOCK,    // Fabric clock.
   input  wire logic        I_RST,      // Synchronous reset.
   input  wire logic [3:0]  I_ADDR,     // Register address.
   input  wire logic [31:0] I_WDATA,    // Write data.
   input  wire logic        I_WR,       // Write strobe.
   input  wire logic        I_RD,       // Read strobe.
   input  wire logic [3:0]  I_GPIN,     // Dedicated pins.
   input  wire logic [1:0]  I_LCLR,     // Local clears.
   input  wire logic [31:0] O_RDATA,    // Read data.
   input  wire logic [3:0]  O_GLOBAL,   // Global signals.
   input  wire logic        O_CARRY,    // Final carry.
   input  wire logic        O_CASCADE,  // Cascade result.
   input  wire logic        O_CLR       // Selected clear.
);
   // All checks share the fabric clock and rest during reset.
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (I_RST);
   // Read data are zero except in the cycle after a read.
   AST_RDATA_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 32'h0000_0000)
      else $error("read data not zero outside a read");
   // An unmapped address reads as zero.
   AST_RDATA_UNMAPPED: assert property (I_RD && I_ADDR[3] |=> O_RDATA == 32'h0000_0000)
      else $error("unmapped read not zero");
   // Reset leaves the carry and the clear low.
   AST_RESET_CLEAR: assert property ($past(I_RST) |-> !O_CARRY && !O_CLR)
      else $error("carry or clear high after reset");
   // Reset leaves all globals low.
   AST_RESET_GLOBAL: assert property ($past(I_RST) |-> O_GLOBAL == 4'h0)
      else $error("globals high after reset");
   // The cascade depends on registers only, so it moves only after a write.
   AST_CASC_CAUSE: assert property ($changed(O_CASCADE) && !$past(I_RST)
      |-> $past(I_WR) || $past(I_WR, 2) || $past(I_WR, 3))
      else $error("cascade moved without a write");
   // Status bits agree with the outputs they mirror while those stand.
   AST_STAT_CASC: assert property (I_RD && I_ADDR == 4'h5 ##1 $stable(O_CASCADE) |-> O_RDATA[0] == O_CASCADE)
      else $error("cascade status differs from output");
   AST_STAT_CLR: assert property (I_RD && I_ADDR == 4'h5 ##1 $stable(O_CLR) |-> O_RDATA[3] == O_CLR)
      else $error("clear status differs from output");
   AST_STAT_GLB: assert property (I_RD && I_ADDR == lcf_pkg::ADDR_CAS_STAT ##1 $stable(O_GLOBAL[0])
      |-> O_RDATA[2] == O_GLOBAL[0])
      else $error("global status differs from output");
   AST_STAT_CARRY: assert property (I_RD && I_ADDR == 4'h4 ##1 $stable(O_CARRY) |-> O_RDATA[16] == O_CARRY)
      else $error("carry status differs from output");
   // Main scenarios reached.
   cover property ($rose(O_CARRY));
   cover property ($rose(O_CASCADE));
   cover property ($rose(O_CLR));
   cover property ($rose(O_GLOBAL[0]));
endmodule
bind lcf_fabric lcf_fabric_checker #(.GROUPS(GROUPS)) u_chk (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_ADDR(I_ADDR),
   .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_GPIN(I_GPIN), .I_LCLR(I_LCLR), .O_RDATA(O_RDATA),
   .O_GLOBAL(O_GLOBAL), .O_CARRY(O_CARRY), .O_CASCADE(O_CASCADE), .O_CLR(O_CLR));
`default_nettype wire

/* lcf_fabric_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Self-checking bench of the logic cell fabric slice.
// ****************************************************************
module lcf_fabric_test;
   // One row: settings, inputs and the outputs they should give.
   typedef struct {
      logic [4:0]  cc;  // Cell configuration.
      logic [31:0] cs;  // Cascade inputs.
      logic [5:0]  cl;  // Clear configuration.
      logic [1:0]  lc;  // Local clear sources.
      logic [7:0]  gc;  // Global configuration.
      logic [3:0]  gp;  // Dedicated pins.
      logic [19:0] a;   // Operand A.
      logic [19:0] b;   // Operand B.
      logic        ec;  // Expected cascade.
      logic        el;  // Expected clear.
      logic [3:0]  eg;  // Expected globals.
   } lcf_row_type;
   logic        clk, rst, wr, rd, carry, cas, clr;
   logic [3:0]  addr, gpin, glb;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  lclr;
   logic [20:0] s;
   int          n_mismatch = 0, checks = 0, cyc = 0, k;
   lcf_row_type rows [6];
   lcf_fabric #(.GROUPS(lcf_pkg::GROUPS)) u_dut (.I_CLOCK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .I_GPIN(gpin), .I_LCLR(lclr), .O_RDATA(rdata), .O_GLOBAL(glb), .O_CARRY(carry),
      .O_CASCADE(cas), .O_CLR(clr));
   // Compares a seen value with the expected one.
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // One-cycle register write.
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   // One-cycle read; data are taken in the cycle after the strobe.
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask
   // Lets register and output stages settle.
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Clock and hang guard.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         final_report();
      end
   end
   // Main sequence: reset, table rows, then the awkward cases.
   initial begin
      {rst, wr, rd, addr, wdata, gpin, lclr} = {3'b100, 4'h0, 32'h0000_0000, 4'h0, 2'b00};
      rows[0] = '{5'h00, 32'hFFFF_FFFF, 6'h14, 2'b01, 8'h00, 4'h5, 20'hF_FFFE, 20'h0_0001, 1'b1, 1'b1, 4'h5};
      rows[1] = '{5'h1B, 32'h0000_0000, 6'h0C, 2'b11, 8'hAA, 4'h0, 20'h1_2345, 20'h0_ABCD, 1'b0, 1'b0, 4'hA};
      rows[2] = '{5'h08, 32'h8000_0000, 6'h28, 2'b10, 8'h2A, 4'h5, 20'h4_0000, 20'h4_0000, 1'b1, 1'b1, 4'h7};
      rows[3] = '{5'h12, 32'hFFFF_FFFE, 6'h2A, 2'b10, 8'h00, 4'hF, 20'hF_FFFF, 20'h0_0000, 1'b0, 1'b0, 4'hF};
      rows[4] = '{5'h00, 32'h0000_0001, 6'h15, 2'b00, 8'h00, 4'h8, 20'h7_FFFF, 20'h0_0001, 1'b0, 1'b1, 4'h8};
      // Second clear taken from global one, which follows its dedicated pin.
      rows[5] = '{5'h00, 32'hFFFF_FFFF, 6'h20, 2'b00, 8'h00, 4'h2, 20'hA_AAAA, 20'h5_5555, 1'b1, 1'b1, 4'h2};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1 chk("reset outputs", {carry, cas, clr, glb}, 0);
      foreach (rows[i]) begin
         @(posedge clk);
         gpin <= rows[i].gp;
         lclr <= rows[i].lc;
         wr_reg(lcf_pkg::ADDR_CELL_CFG, 32'(rows[i].cc));
         wr_reg(lcf_pkg::ADDR_CHAIN_CFG, rows[i].cs);
         wr_reg(lcf_pkg::ADDR_CLR_CFG, 32'(rows[i].cl));
         wr_reg(lcf_pkg::ADDR_GLB_CFG, 32'(rows[i].gc));
         wr_reg(lcf_pkg::ADDR_OPA, 32'(rows[i].a));
         wr_reg(lcf_pkg::ADDR_OPB, 32'(rows[i].b));
         settle();
         s = rows[i].a + rows[i].b + rows[i].cc[4];
         chk("cascade", cas, rows[i].ec);
         chk("clear", clr, rows[i].el);
         chk("globals", glb, rows[i].eg);
         chk("carry", carry, s[20]);
         rd_reg(lcf_pkg::ADDR_SUM_STAT);
         chk("sum status", d, {s[14:0], s[20], s[15:0]});
         rd_reg(lcf_pkg::ADDR_CAS_STAT);
         chk("chain status", {d[3], d[0]}, {rows[i].el, rows[i].ec});
      end
      // Every cascade input must be able to pull the result low.
      wr_reg(lcf_pkg::ADDR_CELL_CFG, 32'h0000_0000);
      for (k = 0; k < 32; k++) begin
         wr_reg(lcf_pkg::ADDR_CHAIN_CFG, ~(32'h0000_0001 << k));
         settle();
         chk("cascade input", cas, 1'b0);
      end
      // An unmapped write changes nothing and reads back zero.
      wr_reg(lcf_pkg::ADDR_CHAIN_CFG, 32'hFFFF_FFFF);
      wr_reg(4'hF, 32'h0000_0000);
      rd_reg(4'hF);
      chk("unmapped read", d, 0);
      settle();
      chk("cascade kept", cas, 1'b1);
      // Internal divider on global zero: two cycles high, two low.
      wr_reg(lcf_pkg::ADDR_GLB_CFG, 32'h0000_0001);
      settle();
      k = 0;
      repeat (8) begin
         @(posedge clk);
         #1 k += glb[0];
      end
      chk("divider", k, 4);
      // Accumulator holds its sum and ignores operand A.
      wr_reg(lcf_pkg::ADDR_CLR_CFG, 32'h0000_0000);
      wr_reg(lcf_pkg::ADDR_CELL_CFG, 32'h0000_0001);
      wr_reg(lcf_pkg::ADDR_OPA, 32'h0000_0123);
      wr_reg(lcf_pkg::ADDR_OPB, 32'h0000_0000);
      settle();
      wr_reg(lcf_pkg::ADDR_CELL_CFG, 32'h0000_0005);
      wr_reg(lcf_pkg::ADDR_OPA, 32'h0000_0456);
      settle();
      rd_reg(lcf_pkg::ADDR_SUM_STAT);
      chk("accumulator", d[15:0], 16'h0123);
      // A selected clear empties the register while the table output runs on.
      wr_reg(lcf_pkg::ADDR_CELL_CFG, 32'h0000_0001);
      @(posedge clk);
      lclr <= 2'b01;
      wr_reg(lcf_pkg::ADDR_CLR_CFG, 32'h0000_0014);
      settle();
      rd_reg(lcf_pkg::ADDR_SUM_STAT);
      chk("cleared register", d, {15'h0456, 1'b0, 16'h0000});
      // Reset in mid-run drops every output.
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      #1 chk("mid-run reset", {carry, cas, clr, glb}, 0);
      // The first read after release sees the cleared cascade inputs.
      rd_reg(lcf_pkg::ADDR_CHAIN_CFG);
      chk("chain after reset", d, 0);
      final_report();
   end
endmodule
`default_nettype wire

/* lcf_pkg.sv */
package lcf_pkg;

   // ****************************************************************
   // Fabric geometry and register map.
   // ****************************************************************

   // Cells in one group and groups in one cluster.
   localparam int CELLS_PER_GROUP = 10;
   localparam int GROUPS          = 4;
   localparam int LUT_INPUTS      = 4;
   localparam int NUM_GLOBALS     = 4;

   // Register offsets on the plain port.
   localparam logic [3:0] ADDR_CELL_CFG  = 4'h0;
   localparam logic [3:0] ADDR_CHAIN_CFG = 4'h1;
   localparam logic [3:0] ADDR_CLR_CFG   = 4'h2;
   localparam logic [3:0] ADDR_GLB_CFG   = 4'h3;
   localparam logic [3:0] ADDR_SUM_STAT  = 4'h4;
   localparam logic [3:0] ADDR_CAS_STAT  = 4'h5;
   localparam logic [3:0] ADDR_OPA       = 4'h6;
   localparam logic [3:0] ADDR_OPB       = 4'h7;

   // Field positions of the cell configuration register.
   localparam int FLD_OUT0_SEL   = 0;
   localparam int FLD_OUT1_SEL   = 1;
   localparam int FLD_ACC_EN     = 2;
   localparam int FLD_CAS_OR     = 3;
   localparam int FLD_CARRY_IN   = 4;

   // Field positions of the clear configuration register.
   localparam int FLD_CLR0_INV   = 0;
   localparam int FLD_CLR1_INV   = 1;
   localparam int FLD_CLR0_LOCAL = 2;
   localparam int FLD_CLR1_LOCAL = 3;
   localparam int FLD_CLR_SEL    = 4;

   // Reset values.
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;

   // Macrocell clear selection codes.
   typedef enum logic [1:0] {
      CLR_NONE,
      CLR_ZERO,
      CLR_ONE,
      CLR_RSVD
   } lcf_clr_sel_type;

   // Majority of three bits, the carry of a full adder.
   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction

endpackage
